// ### design/ppl_pkg.sv
// Package with constants and carrier types for the port latch and pull-up block.
// Function
// - Pull-up connects per bit only when its select bit is set and pin is input.
// - Pull-up stays off for output-mode pins and alternate-function outputs.
// - Reset clears every pull-up select register to zero.
// - Select bit 0 leaves pull-up off; 1 asks for it connected.
// - Pull-up selects accept whole-byte writes and single-bit manipulations; here bit manipulation reaches only the output latch.
// - A single-bit manipulation runs as a full 8-bit port access.
// - In output mode a write loads the latch, which drives the pin.
// - Output latch holds its value until the next write, in both modes.
// - Reset clears the output latch contents.
// - In input mode a write updates the latch, buffer off, pin unaffected.
// - In output mode a read returns the latch and leaves it unchanged.
// - In input mode a read returns pin levels and leaves the latch unchanged.
// - Output-mode read-modify-write works on the latch, stores and drives the result.
// - Input-mode read-modify-write works on pin levels, stores result in latch only.
// - Direction bit 0 selects output with buffer on; 1 selects input, buffer off.
package ppl_pkg;

  localparam int PPL_NPORT  = 6;
  localparam int PPL_ADDR_W = 20;

  // Register indices; the byte address is four times the index.
  // Port order, lowest first: 0, 1, 3, 7, 12, 14.
  localparam logic [PPL_NPORT-1:0][15:0] PPL_LATCH_IDX =
    {16'hFF0E, 16'hFF0C, 16'hFF07, 16'hFF03, 16'hFF01, 16'hFF00};
  localparam logic [PPL_NPORT-1:0][15:0] PPL_DIR_IDX =
    {16'hFF2E, 16'hFF2C, 16'hFF27, 16'hFF23, 16'hFF21, 16'hFF20};
  localparam logic [PPL_NPORT-1:0][15:0] PPL_PULL_IDX =
    {16'hFF3E, 16'hFF3C, 16'hFF37, 16'hFF33, 16'hFF31, 16'hFF30};
  localparam logic [PPL_NPORT-1:0][15:0] PPL_BITOP_IDX =
    {16'hFF45, 16'hFF44, 16'hFF43, 16'hFF42, 16'hFF41, 16'hFF40};

  // Bits that have a pin behind them.
  localparam logic [PPL_NPORT-1:0][7:0] PPL_PIN_MASK =
    {8'h01, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'h0F};

  localparam logic [7:0] PPL_LATCH_RST = 8'h00;
  localparam logic [7:0] PPL_DIR_RST   = 8'hFF;
  localparam logic [7:0] PPL_PULL_RST  = 8'h00;

  // Bit manipulation register fields: bit number and operation.
  localparam int PPL_BOP_BIT_LSB = 0;
  localparam int PPL_BOP_OP_LSB  = 3;
  localparam logic [1:0] PPL_OP_SET  = 2'h0;
  localparam logic [1:0] PPL_OP_CLR  = 2'h1;
  localparam logic [1:0] PPL_OP_INV  = 2'h2;
  localparam logic [1:0] PPL_OP_LOAD = 2'h3;

  localparam logic [1:0] PPL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPL_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPL_K_LATCH = 2'h0,
    PPL_K_DIR   = 2'h1,
    PPL_K_PULL  = 2'h2,
    PPL_K_BITOP = 2'h3
  } ppl_kind_t;

  typedef struct packed {
    logic      hit;
    ppl_kind_t kind;
    logic [2:0] port;
  } ppl_dec_t;

  typedef logic [PPL_NPORT-1:0][7:0] ppl_port_vec_t;

  typedef struct packed {
    logic                  awvalid;
    logic [PPL_ADDR_W-1:0] awaddr;
    logic                  wvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bready;
    logic                  arvalid;
    logic [PPL_ADDR_W-1:0] araddr;
    logic                  rready;
  } ppl_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ppl_axi_rsp_t;

endpackage : ppl_pkg

// ### design/ppl_port_io.sv
// Port output latches, direction and pull-up selection behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module ppl_port_io
  import ppl_pkg::*;
(
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite slave
  input  wire ppl_axi_req_t  axi_req,
  output wire ppl_axi_rsp_t  axi_rsp,
  // Alternate-function output enables from peripherals
  input  wire ppl_port_vec_t alt_out_en,
  // Pins
  input  wire ppl_port_vec_t pin_in,
  output wire ppl_port_vec_t pin_out,
  output wire ppl_port_vec_t pin_oe,
  output wire ppl_port_vec_t pullup_en
);

  typedef enum logic [1:0] {
    PPL_W_IDLE = 2'b01,
    PPL_W_RESP = 2'b10
  } ppl_wstate_t;

  typedef struct packed {
    ppl_wstate_t           wst;
    logic                  aw_held;
    logic                  w_held;
    logic [PPL_ADDR_W-1:0] awaddr;
    logic [7:0]            wdata;
    logic                  wlane0;
    ppl_port_vec_t         output_latch;
    ppl_port_vec_t         pin_direction;
    ppl_port_vec_t         pullup_select;
    ppl_port_vec_t         pin_out;
    ppl_port_vec_t         pin_oe;
    ppl_port_vec_t         pullup_en;
    ppl_axi_rsp_t          rsp;
  } ppl_state_t;

  ppl_state_t    st_reg;
  ppl_state_t    st_next;
  ppl_port_vec_t pin_sync;
  logic          lat_we;
  logic          aw_fire;
  logic          w_fire;
  logic          ar_fire;

  // Pin levels cross into the bus clock before anything reads them.
  ppl_sync2 #(
    .W(PPL_NPORT * 8)
  ) u_pin_sync (
    .aclk   (aclk),
    .aresetn(aresetn),
    .d      (pin_in),
    .q      (pin_sync)
  );

  // Decodes a byte address against the four register banks.
  function automatic ppl_dec_t decode(input logic [PPL_ADDR_W-1:0] addr);
    ppl_dec_t r;
    r = '0;
    for (int p = 0; p < PPL_NPORT; p++) begin
      if (addr[1:0] == 2'h0) begin
        if (addr[PPL_ADDR_W-1:2] == 18'(PPL_LATCH_IDX[p])) begin
          r = '{hit: 1'b1, kind: PPL_K_LATCH, port: 3'(p)};
        end
        if (addr[PPL_ADDR_W-1:2] == 18'(PPL_DIR_IDX[p])) begin
          r = '{hit: 1'b1, kind: PPL_K_DIR, port: 3'(p)};
        end
        if (addr[PPL_ADDR_W-1:2] == 18'(PPL_PULL_IDX[p])) begin
          r = '{hit: 1'b1, kind: PPL_K_PULL, port: 3'(p)};
        end
        if (addr[PPL_ADDR_W-1:2] == 18'(PPL_BITOP_IDX[p])) begin
          r = '{hit: 1'b1, kind: PPL_K_BITOP, port: 3'(p)};
        end
      end
    end
    return r;
  endfunction : decode

  // What software sees on a port: latch for outputs, pin level for inputs.
  function automatic logic [7:0] port_view(input logic [7:0] lat, input logic [7:0] dir,
                                           input logic [7:0] pins, input logic [7:0] mask);
    return ((lat & ~dir) | (pins & dir)) & mask;
  endfunction : port_view

  assign aw_fire = axi_req.awvalid && st_reg.rsp.awready;
  assign w_fire  = axi_req.wvalid && st_reg.rsp.wready;
  assign ar_fire = axi_req.arvalid && st_reg.rsp.arready;

  always_comb begin
    ppl_dec_t   wd;
    ppl_dec_t   rd;
    logic [7:0] mask;
    logic [7:0] operand;
    logic [7:0] result;
    logic [2:0] bnum;
    wd      = decode(st_reg.awaddr);
    rd      = decode(axi_req.araddr);
    mask    = PPL_PIN_MASK[wd.port];
    operand = 8'h00;
    result  = 8'h00;
    bnum    = st_reg.wdata[PPL_BOP_BIT_LSB +: 3];
    st_next = st_reg;
    lat_we  = 1'b0;

    // Write channel: address and data are taken in either order.
    if (aw_fire) begin
      st_next.aw_held = 1'b1;
      st_next.awaddr  = axi_req.awaddr;
    end
    if (w_fire) begin
      st_next.w_held = 1'b1;
      st_next.wdata  = axi_req.wdata[7:0];
      st_next.wlane0 = axi_req.wstrb[0];
    end

    case (st_reg.wst)
      PPL_W_IDLE: begin
        if (st_reg.aw_held && st_reg.w_held) begin
          st_next.rsp.bvalid = 1'b1;
          st_next.rsp.bresp  = wd.hit ? PPL_RESP_OKAY : PPL_RESP_SLVERR;
          st_next.wst        = PPL_W_RESP;
          if (wd.hit && st_reg.wlane0) begin
            case (wd.kind)
              PPL_K_LATCH: begin
                // A byte write loads the latch whatever the direction.
                st_next.output_latch[wd.port] = st_reg.wdata & mask;
                lat_we = 1'b1;
              end
              PPL_K_DIR: begin
                st_next.pin_direction[wd.port] = st_reg.wdata | ~mask;
              end
              PPL_K_PULL: begin
                st_next.pullup_select[wd.port] = st_reg.wdata & mask;
              end
              PPL_K_BITOP: begin
                // One bit is named but the whole byte is read and rewritten,
                // so latch bits of input pins pick up their pin levels.
                operand = port_view(st_reg.output_latch[wd.port],
                                    st_reg.pin_direction[wd.port],
                                    pin_sync[wd.port], mask);
                case (st_reg.wdata[PPL_BOP_OP_LSB +: 2])
                  PPL_OP_SET: result = operand | (8'h01 << bnum);
                  PPL_OP_CLR: result = operand & ~(8'h01 << bnum);
                  PPL_OP_INV: result = operand ^ (8'h01 << bnum);
                  default:    result = operand;
                endcase
                st_next.output_latch[wd.port] = result & mask;
                lat_we = 1'b1;
              end
              default: begin
                lat_we = 1'b0;
              end
            endcase
          end
        end
      end
      PPL_W_RESP: begin
        if (axi_req.bready) begin
          st_next.rsp.bvalid = 1'b0;
          st_next.aw_held    = 1'b0;
          st_next.w_held     = 1'b0;
          st_next.wst        = PPL_W_IDLE;
        end
      end
      default: begin
        st_next.wst = PPL_W_IDLE;
      end
    endcase
    st_next.rsp.awready = (st_next.wst == PPL_W_IDLE) && !st_next.aw_held;
    st_next.rsp.wready  = (st_next.wst == PPL_W_IDLE) && !st_next.w_held;

    // Read channel: one read at a time, answered the cycle after the address.
    if (ar_fire) begin
      st_next.rsp.rvalid  = 1'b1;
      st_next.rsp.arready = 1'b0;
      st_next.rsp.rresp   = rd.hit ? PPL_RESP_OKAY : PPL_RESP_SLVERR;
      st_next.rsp.rdata   = 32'h0000_0000;
      if (rd.hit) begin
        case (rd.kind)
          PPL_K_DIR: begin
            st_next.rsp.rdata[7:0] = st_reg.pin_direction[rd.port];
          end
          PPL_K_PULL: begin
            st_next.rsp.rdata[7:0] = st_reg.pullup_select[rd.port];
          end
          default: begin
            st_next.rsp.rdata[7:0] = port_view(st_reg.output_latch[rd.port],
                                               st_reg.pin_direction[rd.port],
                                               pin_sync[rd.port],
                                               PPL_PIN_MASK[rd.port]);
          end
        endcase
      end
    end else if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid  = 1'b0;
      st_next.rsp.arready = 1'b1;
    end

    // Pin drivers are registered so the pads see glitch-free levels.
    for (int p = 0; p < PPL_NPORT; p++) begin
      st_next.pin_out[p] = st_next.output_latch[p];
      st_next.pin_oe[p]  = ~st_next.pin_direction[p] & PPL_PIN_MASK[p];
      st_next.pullup_en[p] = st_next.pullup_select[p] & st_next.pin_direction[p]
                             & ~alt_out_en[p] & PPL_PIN_MASK[p];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg               <= '0;
      st_reg.wst           <= PPL_W_IDLE;
      st_reg.output_latch  <= {PPL_NPORT{PPL_LATCH_RST}};
      st_reg.pin_direction <= {PPL_NPORT{PPL_DIR_RST}};
      st_reg.pullup_select <= {PPL_NPORT{PPL_PULL_RST}};
      st_reg.rsp.awready   <= 1'b1;
      st_reg.rsp.wready    <= 1'b1;
      st_reg.rsp.arready   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp   = st_reg.rsp;
  assign pin_out   = st_reg.pin_out;
  assign pin_oe    = st_reg.pin_oe;
  assign pullup_en = st_reg.pullup_en;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Pull-up only where the matching select bit is set.
  a_pullup_needs_select: assert property (
    (pullup_en & ~st_reg.pullup_select) == '0
  ) else $error("pull-up enabled without select bit");

  // Pull-up never on a driven pin or an alternate-function output.
  a_pullup_off_output: assert property (
    ((pullup_en & st_reg.pin_oe) == '0) && ((pullup_en & $past(alt_out_en)) == '0)
  ) else $error("pull-up enabled on an output pin");

  // Reset leaves latches and pull-up selects at zero.
  a_reset_clears_regs: assert property (disable iff (1'b0)
    !aresetn |=> (st_reg.pullup_select == '0) && (st_reg.output_latch == '0)
  ) else $error("reset did not clear latch or pull-up select");

  // Latch moves only on a latch or bit manipulation write.
  a_latch_holds_value: assert property (
    !lat_we |=> $stable(st_reg.output_latch)
  ) else $error("output latch changed without a write");

  // Pins are driven exactly where direction says output, checked the cycle after it changes.
  a_drive_follows_dir: assert property (
    $changed(st_reg.pin_direction) |=> (pin_oe == (~$past(st_reg.pin_direction, 1) & PPL_PIN_MASK))
  ) else $error("output enable does not follow direction");

  // Input pins are never driven, whatever the latch holds.
  a_input_not_driven: assert property (
    (pin_oe & st_reg.pin_direction) == '0
  ) else $error("input-mode pin is being driven");

  // Latch and pull-up select bits without a pin read as zero and never store a one.
  a_ghost_bits_zero: assert property (
    ((st_reg.pullup_select & ~PPL_PIN_MASK) == '0) && ((st_reg.output_latch & ~PPL_PIN_MASK) == '0)
  ) else $error("unimplemented bit holds a one");

  // A taken read answers on the next cycle and refuses a second address meanwhile.
  a_read_answer_time: assert property (
    ar_fire |=> st_reg.rsp.rvalid && !st_reg.rsp.arready
  ) else $error("read answer late or address not refused");

  // Once address and data are both held, the write response follows on the next edge.
  a_write_answer_time: assert property (
    st_reg.aw_held && st_reg.w_held && (st_reg.wst == PPL_W_IDLE) |=> st_reg.rsp.bvalid
  ) else $error("write response late");

  // A selected input pin that no peripheral drives has its pull-up on, and no other pin.
  a_pullup_when_allowed: assert property (
    pullup_en == (st_reg.pullup_select & st_reg.pin_direction
                  & ~$past(alt_out_en) & PPL_PIN_MASK)
  ) else $error("pull-up state differs from select, direction and drive");

  // Pins carry the latch contents in every mode.
  a_pin_out_latch: assert property (
    pin_out == st_reg.output_latch
  ) else $error("pin output differs from latch");

endmodule : ppl_port_io
`default_nettype wire

// ### design/ppl_sync2.sv
// Two-stage synchroniser for the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module ppl_sync2 #(
  parameter int W = 48
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppl_sync_st_t;

  ppl_sync_st_t st_reg;
  ppl_sync_st_t st_next;

  // The first stage feeds only the second stage.
  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule : ppl_sync2
`default_nettype wire

// ### testbench/ppl_pin_env.sv
// Pin-side model: external drivers, pull-ups and floating lines.
`timescale 1ns/1ps
`default_nettype none
module ppl_pin_env
  import ppl_pkg::*;
(
  // Clock
  input  wire logic          aclk,
  // Device pin controls
  input  wire ppl_port_vec_t pin_out,
  input  wire ppl_port_vec_t pin_oe,
  input  wire ppl_port_vec_t pullup_en,
  // External drivers set by the bench
  input  wire ppl_port_vec_t ext_val,
  input  wire ppl_port_vec_t ext_en,
  // Resolved pin levels
  output var  ppl_port_vec_t pin_lvl
);
  // A floating pin flips every cycle, so a stale level can never pass for a driven one.
  logic float_reg = 1'b0;
  always @(posedge aclk) float_reg <= ~float_reg;
  always_comb begin
    for (int p = 0; p < PPL_NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b]) pin_lvl[p][b] = pin_out[p][b];
        else if (ext_en[p][b]) pin_lvl[p][b] = ext_val[p][b];
        else if (pullup_en[p][b]) pin_lvl[p][b] = 1'b1;
        else pin_lvl[p][b] = float_reg;
      end
    end
  end
endmodule : ppl_pin_env
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the port latch and pull-up block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, a); end end
module tb_top;
  import ppl_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  ppl_axi_req_t  req = '0;
  ppl_axi_rsp_t  rsp;
  ppl_port_vec_t alt_out_en = '0;
  ppl_port_vec_t ext_val = '0;
  ppl_port_vec_t ext_en = '1;
  ppl_port_vec_t pin_lvl, pin_out, pin_oe, pullup_en;
  int            errors = 0;
  int            total_checks = 0;

  always #12.5 aclk = ~aclk;

  ppl_port_io dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .alt_out_en(alt_out_en), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en));
  ppl_pin_env env_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // One bus access; each channel is held until its own handshake edge.
  task automatic axi(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int   n;
    logic a, w, b;
    n = 0;
    rd = '0;
    rs = 2'h3;
    b = 1'b0;
    @(posedge aclk);
    if (wr) begin
      req.awvalid <= 1'b1;
      req.awaddr  <= {2'h0, idx, 2'h0};
      req.wvalid  <= 1'b1;
      req.wdata   <= {24'h0, d};
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
    end else begin
      req.arvalid <= 1'b1;
      req.araddr  <= {2'h0, idx, 2'h0};
      req.rready  <= 1'b1;
    end
    while (!b && n < 100) begin
      @(negedge aclk);
      a = (req.awvalid & rsp.awready) | (req.arvalid & rsp.arready);
      w = req.wvalid & rsp.wready;
      b = (req.bready & rsp.bvalid) | (req.rready & rsp.rvalid);
      if (b) begin
        rd = rsp.rdata;
        rs = wr ? rsp.bresp : rsp.rresp;
      end
      @(posedge aclk);
      if (a && wr) req.awvalid <= 1'b0;
      if (a && !wr) req.arvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      if (b) req.rready <= 1'b0;
      n++;
    end
    if (!b) errors++;
    @(negedge aclk);
  endtask : axi

  task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] x;
    logic [1:0]  r;
    axi(1'b1, idx, d, x, r);
    `CHK("bresp", PPL_RESP_OKAY, r)
  endtask : wreg

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] x;
    logic [1:0]  r;
    axi(1'b0, idx, 8'h00, x, r);
    `CHK("rdata", {24'h0, e}, x)
  endtask : rchk

  task automatic t_reset;
    for (int p = 0; p < PPL_NPORT; p++) rchk(PPL_PULL_IDX[p], 8'h00);
    `CHK("pullup_en", '0, pullup_en)
    `CHK("pin_out", '0, pin_out)
    `CHK("pin_oe", '0, pin_oe)
  endtask : t_reset

  task automatic t_pullup;
    wreg(PPL_PULL_IDX[1], 8'hA5);
    `CHK("pullup_en", 8'hA5, pullup_en[1])
    rchk(PPL_PULL_IDX[1], 8'hA5);
    wreg(PPL_DIR_IDX[1], 8'h0F);
    `CHK("pullup_en", 8'h05, pullup_en[1])
    `CHK("pin_oe", 8'hF0, pin_oe[1])
    @(posedge aclk);
    alt_out_en[1] <= 8'h01;
    repeat (2) @(negedge aclk);
    `CHK("pullup_en", 8'h04, pullup_en[1])
    @(posedge aclk);
    alt_out_en[1] <= 8'h00;
    wreg(PPL_PULL_IDX[0], 8'hFF);
    rchk(PPL_PULL_IDX[0], 8'h0F);
    `CHK("pullup_en", 8'h0F, pullup_en[0])
    // With the outside drivers gone, only the pull-ups hold port 0 high.
    @(posedge aclk);
    ext_en[0] <= 8'h00;
    repeat (3) @(negedge aclk);
    rchk(PPL_LATCH_IDX[0], 8'h0F);
  endtask : t_pullup

  // Port 1: low nibble input, high nibble output; every operation codes in turn.
  task automatic t_bitops;
    logic [7:0] lat, view;
    logic [2:0] bn [4];
    lat = 8'h00;
    bn = '{3'd5, 3'd1, 3'd7, 3'd0};
    @(posedge aclk);
    ext_val[1] <= 8'h0A;
    repeat (4) @(negedge aclk);
    for (int op = 0; op < 4; op++) begin
      view = (lat & 8'hF0) | 8'h0A;
      case (op)
        0: lat = view | (8'h01 << bn[op]);
        1: lat = view & ~(8'h01 << bn[op]);
        2: lat = view ^ (8'h01 << bn[op]);
        default: lat = view;
      endcase
      wreg(PPL_BITOP_IDX[1], {op[1:0], bn[op]});
      `CHK("pin_out", lat, pin_out[1])
      `CHK("pin_oe", 8'hF0, pin_oe[1])
      rchk(PPL_LATCH_IDX[1], (lat & 8'hF0) | 8'h0A);
    end
  endtask : t_bitops

  task automatic t_latch;
    @(posedge aclk);
    ext_val[3] <= 8'hC3;
    wreg(PPL_LATCH_IDX[3], 8'h3C);
    `CHK("pin_oe", 8'h00, pin_oe[3])
    rchk(PPL_LATCH_IDX[3], 8'hC3);
    `CHK("pin_out", 8'h3C, pin_out[3])
    @(posedge aclk);
    ext_en[3] <= 8'h00;
    wreg(PPL_DIR_IDX[3], 8'h00);
    `CHK("pin_oe", 8'hFF, pin_oe[3])
    `CHK("pin_out", 8'h3C, pin_out[3])
    rchk(PPL_LATCH_IDX[3], 8'h3C);
    `CHK("pin_out", 8'h3C, pin_out[3])
  endtask : t_latch

  task automatic t_unmapped;
    logic [31:0] x;
    logic [1:0]  r;
    axi(1'b0, 16'h0100, 8'h00, x, r);
    `CHK("rresp", PPL_RESP_SLVERR, r)
    `CHK("rdata", 32'h0, x)
    axi(1'b1, 16'h0100, 8'h55, x, r);
    `CHK("bresp", PPL_RESP_SLVERR, r)
  endtask : t_unmapped

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(negedge aclk);
    t_reset();
    t_pullup();
    t_bitops();
    t_latch();
    t_unmapped();
    give_verdict();
  end

  // The tests take well under a thousand cycles; this bound only cuts a hang.
  initial begin
    #(25 * 5000);
    errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
